/* File: verilog/link_board_host_port.sv */
// host-facing port of the link interface device: dma, programmed i/o, irq, rates
`timescale 1ns/1ps

module link_board_host_port (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic master_clear_n,
  input wire logic cs_n,
  input wire logic rd_strobe_n,
  input wire logic wr_strobe_n,
  input wire logic [15:0] addr_in,
  output logic [15:0] addr_out,
  output logic addr_oe,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic reply_n,
  output logic dma_fetch_req_n,
  output logic dma_store_req_n,
  input wire logic dma_grant_n,
  output logic irq_out_n,
  input wire logic [3:0] tx_speed_sel,
  input wire logic [3:0] rx_speed_sel,
  input wire logic [7:0] rate_switchpack,
  output logic tx_bit_clk,
  output logic rx_bit_clk,
  input wire logic term_ready,
  input wire logic remote_loop,
  input wire logic local_loop,
  input wire logic fetch_need,
  input wire logic [15:0] fetch_addr,
  output logic [7:0] fetch_byte,
  output logic fetch_done,
  input wire logic store_need,
  input wire logic [15:0] store_addr,
  input wire logic [7:0] store_byte,
  output logic store_done,
  input wire logic irq_event
);

  // ************************************************
  // 1 MHz system tick
  // ************************************************
  logic [4:0] tick_cnt;
  logic sys_tick;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt <= 5'h00;
      sys_tick <= 1'b0;
    end else begin
      tick_cnt <= (tick_cnt == link_port_pkg::SYS_TICK_LAST) ? 5'h00 : tick_cnt + 5'h01;
      sys_tick <= (tick_cnt == link_port_pkg::SYS_TICK_LAST);
    end
  end

  // ************************************************
  // bit rate selection
  // ************************************************
  // switches pull low when on; all off leaves the program lines in charge
  logic [3:0] tx_rate_code;
  logic [3:0] rx_rate_code;
  logic tx_clk_raw;
  logic rx_clk_raw;

  assign tx_rate_code = tx_speed_sel & rate_switchpack[3:0];
  assign rx_rate_code = rx_speed_sel & rate_switchpack[7:4];

  bit_rate_gen tx_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .sys_tick(sys_tick),
    .rate_code(tx_rate_code),
    .bit_clk(tx_clk_raw)
  );

  bit_rate_gen rx_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .sys_tick(sys_tick),
    .rate_code(rx_rate_code),
    .bit_clk(rx_clk_raw)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_bit_clk <= 1'b0;
      rx_bit_clk <= 1'b0;
    end else begin
      tx_bit_clk <= tx_clk_raw;
      rx_bit_clk <= rx_clk_raw;
    end
  end

  // ************************************************
  // dma sequencer
  // ************************************************
  link_port_pkg::dma_state_t state;
  link_port_pkg::dma_state_t next_state;
  logic granted;
  logic dma_busy;

  assign granted = !dma_grant_n;
  assign dma_busy = (state != link_port_pkg::DMA_IDLE);

  always_comb begin
    next_state = state;
    case (state)
      link_port_pkg::DMA_IDLE: begin
        if (fetch_need) begin
          next_state = link_port_pkg::DMA_FETCH_REQ;
        end else if (store_need) begin
          next_state = link_port_pkg::DMA_STORE_REQ;
        end
      end
      link_port_pkg::DMA_FETCH_REQ: begin
        if (granted) begin
          next_state = link_port_pkg::DMA_FETCH_XFER;
        end
      end
      link_port_pkg::DMA_FETCH_XFER: begin
        if (!granted) begin
          next_state = link_port_pkg::DMA_IDLE;
        end
      end
      link_port_pkg::DMA_STORE_REQ: begin
        if (granted) begin
          next_state = link_port_pkg::DMA_STORE_XFER;
        end
      end
      link_port_pkg::DMA_STORE_XFER: begin
        if (!granted) begin
          next_state = link_port_pkg::DMA_IDLE;
        end
      end
      default: next_state = link_port_pkg::DMA_IDLE;
    endcase
  end

  // address is caught as the request starts, so it holds still on the bus
  logic [15:0] next_addr_out;
  logic next_fetch_req;
  logic next_store_req;

  assign next_addr_out = (state == link_port_pkg::DMA_IDLE) ?
    (fetch_need ? fetch_addr : store_addr) : addr_out;
  assign next_fetch_req = (next_state == link_port_pkg::DMA_FETCH_REQ);
  assign next_store_req = (next_state == link_port_pkg::DMA_STORE_REQ);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= link_port_pkg::DMA_IDLE;
      addr_out <= link_port_pkg::ADDR_ZERO;
      addr_oe <= 1'b0;
      dma_fetch_req_n <= 1'b1;
      dma_store_req_n <= 1'b1;
      fetch_byte <= link_port_pkg::BYTE_ZERO;
      fetch_done <= 1'b0;
      store_done <= 1'b0;
    end else begin
      state <= next_state;
      addr_out <= next_addr_out;
      addr_oe <= (next_state != link_port_pkg::DMA_IDLE);
      dma_fetch_req_n <= !next_fetch_req;
      dma_store_req_n <= !next_store_req;
      // take the byte only while granted: at the release edge the bus is stale
      if (state == link_port_pkg::DMA_FETCH_XFER && granted) begin
        fetch_byte <= data_in;
      end
      fetch_done <= (state == link_port_pkg::DMA_FETCH_XFER) && !granted;
      store_done <= (state == link_port_pkg::DMA_STORE_XFER) && !granted;
    end
  end

  // ************************************************
  // programmed i/o
  // ************************************************
  logic rd_act;
  logic wr_act;
  logic wr_prev;
  logic wr_take;
  logic [7:0] ctrl;
  logic [7:0] status;
  logic pending;
  logic [7:0] rd_mux;
  logic [7:0] next_ctrl;
  logic next_pending;

  assign rd_act = !cs_n && !rd_strobe_n;
  assign wr_act = !cs_n && !wr_strobe_n;
  assign wr_take = wr_act && !wr_prev;

  assign status = {3'h0, local_loop, remote_loop, term_ready, dma_busy, pending};
  assign rd_mux = (addr_in[1:0] == link_port_pkg::REG_CTRL) ? ctrl :
                  (addr_in[1:0] == link_port_pkg::REG_STATUS) ? status :
                  (addr_in[1:0] == link_port_pkg::REG_RATE) ? {rx_rate_code, tx_rate_code} :
                  {4'h0, rx_speed_sel};

  // master clear keeps the two protected control bits
  assign next_ctrl = !master_clear_n ? (ctrl & link_port_pkg::CTRL_KEEP_MASK) :
    (wr_take && addr_in[1:0] == link_port_pkg::REG_CTRL) ? data_in : ctrl;
  // a new event wins over a write-one clear in the same cycle
  assign next_pending = irq_event ||
    (master_clear_n && pending &&
     !(wr_take && addr_in[1:0] == link_port_pkg::REG_STATUS && data_in[link_port_pkg::STAT_PEND]));

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_prev <= 1'b0;
      ctrl <= link_port_pkg::CTRL_RESET;
      pending <= 1'b0;
      reply_n <= 1'b1;
      irq_out_n <= 1'b1;
      data_out <= link_port_pkg::BYTE_ZERO;
      data_oe <= 1'b0;
    end else begin
      wr_prev <= wr_act;
      ctrl <= next_ctrl;
      pending <= next_pending;
      reply_n <= !(rd_act || wr_act);
      irq_out_n <= !(next_pending && next_ctrl[link_port_pkg::CTRL_IRQ_EN]);
      // the dma store owns the data bus while granted; reads wait
      if (next_state == link_port_pkg::DMA_STORE_XFER) begin
        data_out <= store_byte;
        data_oe <= 1'b1;
      end else begin
        data_out <= rd_mux;
        data_oe <= rd_act && !granted;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  sequence fetch_grant_s;
    !dma_fetch_req_n ##1 (state == link_port_pkg::DMA_FETCH_XFER);
  endsequence

  sequence selected_s;
    !cs_n && (!rd_strobe_n || !wr_strobe_n);
  endsequence

  fetch_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == link_port_pkg::DMA_IDLE && fetch_need) |=> !dma_fetch_req_n)
    else $error("fetch request not raised");

  store_start_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == link_port_pkg::DMA_IDLE && store_need && !fetch_need) |=> !dma_store_req_n)
    else $error("store request not raised");

  req_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!dma_fetch_req_n && dma_grant_n) |=> !dma_fetch_req_n)
    else $error("fetch request dropped before grant");

  req_withdraw_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!dma_fetch_req_n && !dma_grant_n) |=> (dma_fetch_req_n && dma_store_req_n))
    else $error("request held after grant");

  addr_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    fetch_grant_s |-> (addr_oe && $stable(addr_out)))
    else $error("dma address not held on the bus");

  store_data_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state == link_port_pkg::DMA_STORE_XFER && granted) |-> (data_oe && addr_oe))
    else $error("store byte not driven during grant");

  reply_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
    selected_s |=> !reply_n)
    else $error("reply missing while selected");

  reply_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cs_n || (rd_strobe_n && wr_strobe_n)) |=> reply_n)
    else $error("reply while not selected");

  clear_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    !master_clear_n |=> (ctrl == ($past(ctrl) & link_port_pkg::CTRL_KEEP_MASK)) &&
      (!pending || $past(irq_event)))
    else $error("master clear did not clear registers");

  irq_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!irq_out_n == (pending && ctrl[link_port_pkg::CTRL_IRQ_EN])))
    else $error("interrupt not requested");

  rate_and_a: assert property (@(posedge clk) disable iff (sys_rst)
    {rx_rate_code, tx_rate_code} == ({rx_speed_sel, tx_speed_sel} & rate_switchpack))
    else $error("rate code not program and switch");

  tick_space_a: assert property (@(posedge clk) disable iff (sys_rst)
    sys_tick |=> !sys_tick [*8])
    else $error("system tick too frequent");

endmodule : link_board_host_port

/* File: common/link_port_pkg.sv */
// constants and types shared by the host port and its rate generator
package link_port_pkg;

  // ************************************************
  // clocking
  // ************************************************
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SYS_TICK_HZ = 1_000_000;
  localparam int unsigned SYS_TICK_CYCLES = CLK_HZ / SYS_TICK_HZ;
  localparam logic [4:0] SYS_TICK_LAST = 5'(SYS_TICK_CYCLES - 1);

  // ************************************************
  // programmed i/o map, indexed by the low address bits
  // ************************************************
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_RATE = 2'h2;
  localparam logic [1:0] REG_LINK = 2'h3;

  // control fields
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'h03;
  localparam int unsigned CTRL_IRQ_EN = 2;

  // status fields
  localparam int unsigned STAT_PEND = 0;
  localparam int unsigned STAT_BUSY = 1;
  localparam int unsigned STAT_TERM_RDY = 2;
  localparam int unsigned STAT_RLOOP = 3;
  localparam int unsigned STAT_LLOOP = 4;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] ADDR_ZERO = 16'h0000;

  // ************************************************
  // bit rate divisors, in 1 MHz ticks per half period
  // ************************************************
  localparam logic [11:0] RATE_DIV [16] = '{
    12'h0FA0, 12'h07D0, 12'h03E8, 12'h01F4, 12'h00FA, 12'h007D, 12'h0064, 12'h0050,
    12'h0040, 12'h0032, 12'h0028, 12'h0020, 12'h0019, 12'h0014, 12'h0010, 12'h0008
  };
  localparam logic [11:0] DIV_ONE = 12'h001;
  localparam logic [11:0] DIV_ZERO = 12'h000;

  typedef enum logic [2:0] {
    DMA_IDLE,
    DMA_FETCH_REQ,
    DMA_FETCH_XFER,
    DMA_STORE_REQ,
    DMA_STORE_XFER
  } dma_state_t;

endpackage : link_port_pkg

/* File: verilog/bit_rate_gen.sv */
// one channel of the sixteen-rate bit clock generator
`timescale 1ns/1ps

module bit_rate_gen (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sys_tick,
  input wire logic [3:0] rate_code,
  output logic bit_clk
);

  logic [11:0] count;
  logic [11:0] half_div;
  logic wrap;

  assign half_div = link_port_pkg::RATE_DIV[rate_code];
  // a code change applies to the running count at once; a count already at or past the new limit wraps on the next tick
  assign wrap = (count + link_port_pkg::DIV_ONE) >= half_div;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= link_port_pkg::DIV_ZERO;
      bit_clk <= 1'b0;
    end else if (sys_tick) begin
      count <= wrap ? link_port_pkg::DIV_ZERO : count + link_port_pkg::DIV_ONE;
      if (wrap) begin
        bit_clk <= ~bit_clk;
      end
    end
  end

  // ************************************************
  // checks
  // ************************************************
  toggle_on_wrap_a: assert property (@(posedge clk) disable iff (sys_rst)
    (sys_tick && wrap) |=> (bit_clk != $past(bit_clk)))
    else $error("bit clock missed its toggle");

  hold_between_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(sys_tick && wrap) |=> $stable(bit_clk))
    else $error("bit clock toggled early");

endmodule : bit_rate_gen

/* File: bench/host_dma_model.sv */
// host cpu side model: grants dma requests, serves and absorbs memory bytes
`timescale 1ns/1ps

module host_dma_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic dma_fetch_req_n,
  input wire logic dma_store_req_n,
  input wire logic [15:0] addr_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [7:0] wait_cycles,
  output logic dma_grant_n,
  output logic mem_drive,
  output logic [7:0] mem_data,
  output logic [7:0] stored_byte,
  output logic [15:0] stored_addr
);
  // ************************************************
  // grant sequencing
  // ************************************************
  logic [7:0] cnt;
  logic fetch_cycle;
  wire logic [7:0] mem_word = addr_out[7:0] ^ addr_out[15:8] ^ 8'hA5;
  // released bus shows the inverse so stale data never passes
  assign mem_drive = !dma_grant_n && fetch_cycle;
  assign mem_data = mem_drive ? mem_word : ~mem_word;
  // shared strobe plus one select per 8K socket
  wire logic socket_write_strobe_n = !(!dma_grant_n && data_oe);
  wire logic [7:0] socket_write_select_n =
    ~(8'h01 << addr_out[15:13]) | {8{socket_write_strobe_n}};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 8'h00;
      dma_grant_n <= 1'b1;
      fetch_cycle <= 1'b0;
    end else if (dma_grant_n) begin
      // grant only answers a live request, after a settable delay
      if (!dma_fetch_req_n || !dma_store_req_n) begin
        cnt <= (cnt == wait_cycles) ? 8'h00 : cnt + 8'h01;
        dma_grant_n <= (cnt != wait_cycles);
        fetch_cycle <= !dma_fetch_req_n;
      end
    end else begin
      // one byte per grant, held three cycles
      cnt <= (cnt == 8'h02) ? 8'h00 : cnt + 8'h01;
      dma_grant_n <= (cnt == 8'h02);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stored_byte <= 8'h00;
      stored_addr <= 16'h0000;
    end else if (!socket_write_strobe_n && socket_write_select_n != 8'hFF) begin
      stored_byte <= data_out;
      stored_addr <= addr_out;
    end
  end
endmodule : host_dma_model

/* File: bench/tb_link_board_host_port.sv */
// self-checking bench for the host port
`timescale 1ns/1ps

module tb_link_board_host_port;
  // ************************************************
  // stimulus and wiring
  // ************************************************
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic master_clear_n = 1'b1, cs_n = 1'b1, rd_strobe_n = 1'b1, wr_strobe_n = 1'b1;
  logic [15:0] addr_in = 16'h0000, fetch_addr = 16'h0000, store_addr = 16'h0000;
  logic [7:0] pio_data = 8'h00, store_byte = 8'h00, wait_cycles = 8'h00, q;
  logic [3:0] tx_speed_sel = 4'hF, rx_speed_sel = 4'hF;
  logic [7:0] rate_switchpack = 8'hFF;
  logic term_ready = 1'b1, remote_loop = 1'b0, local_loop = 1'b1;
  logic fetch_need = 1'b0, store_need = 1'b0, irq_event = 1'b0;
  wire logic [15:0] addr_out, stored_addr;
  wire logic [7:0] data_out, fetch_byte, mem_data, stored_byte;
  wire logic addr_oe, data_oe, reply_n, dma_fetch_req_n, dma_store_req_n, dma_grant_n;
  wire logic irq_out_n, tx_bit_clk, rx_bit_clk, fetch_done, store_done, mem_drive;
  wire logic [7:0] data_in = mem_drive ? mem_data : pio_data;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;

  always #25 clk = ~clk;

  link_board_host_port i_link_board_host_port (.clk(clk), .sys_rst(sys_rst),
    .master_clear_n(master_clear_n), .cs_n(cs_n), .rd_strobe_n(rd_strobe_n),
    .wr_strobe_n(wr_strobe_n), .addr_in(addr_in), .addr_out(addr_out), .addr_oe(addr_oe),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .reply_n(reply_n),
    .dma_fetch_req_n(dma_fetch_req_n), .dma_store_req_n(dma_store_req_n),
    .dma_grant_n(dma_grant_n), .irq_out_n(irq_out_n), .tx_speed_sel(tx_speed_sel),
    .rx_speed_sel(rx_speed_sel), .rate_switchpack(rate_switchpack),
    .tx_bit_clk(tx_bit_clk), .rx_bit_clk(rx_bit_clk), .term_ready(term_ready),
    .remote_loop(remote_loop), .local_loop(local_loop), .fetch_need(fetch_need),
    .fetch_addr(fetch_addr), .fetch_byte(fetch_byte), .fetch_done(fetch_done),
    .store_need(store_need), .store_addr(store_addr), .store_byte(store_byte),
    .store_done(store_done), .irq_event(irq_event));

  host_dma_model i_host_dma_model (.clk(clk), .sys_rst(sys_rst),
    .dma_fetch_req_n(dma_fetch_req_n), .dma_store_req_n(dma_store_req_n),
    .addr_out(addr_out), .data_out(data_out), .data_oe(data_oe), .wait_cycles(wait_cycles),
    .dma_grant_n(dma_grant_n), .mem_drive(mem_drive), .mem_data(mem_data),
    .stored_byte(stored_byte), .stored_addr(stored_addr));

  // ************************************************
  // tasks
  // ************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize

  // hold select and strobe until reply is sampled low, take read data there
  task automatic pio(input logic wr, input logic [1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cs_n <= 1'b0;
    rd_strobe_n <= wr;
    wr_strobe_n <= !wr;
    addr_in <= {14'h0000, a};
    pio_data <= d;
    do begin
      @(posedge clk);
      n++;
    end while (reply_n !== 1'b0 && n < 10);
    q = data_out;
    check(16'(reply_n), 16'h0000);
    check(16'(data_oe), 16'(!wr));
    cs_n <= 1'b1;
    rd_strobe_n <= 1'b1;
    wr_strobe_n <= 1'b1;
    pio_data <= ~d;
    @(posedge clk);
    #1;
    check(16'(reply_n), 16'h0001);
    check(16'(data_oe), 16'h0000);
  endtask : pio

  task automatic xfer(input logic st, input logic [15:0] a, input logic [7:0] b);
    int n;
    n = 0;
    @(posedge clk);
    fetch_need <= !st;
    store_need <= st;
    fetch_addr <= a;
    store_addr <= a;
    store_byte <= b;
    @(posedge clk);
    fetch_need <= 1'b0;
    store_need <= 1'b0;
    #1;
    check(16'({dma_fetch_req_n, dma_store_req_n}), st ? 16'h0002 : 16'h0001);
    check(addr_out, a);
    check(16'(addr_oe), 16'h0001);
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((st ? store_done : fetch_done) !== 1'b1 && n < 40);
    check(16'(n < 40), 16'h0001);
    check(16'({dma_fetch_req_n, dma_store_req_n}), 16'h0003);
    check(16'(addr_oe), 16'h0000);
    if (st) begin
      check(stored_addr, a);
      check(16'(stored_byte), 16'(b));
    end else begin
      check(16'(fetch_byte), 16'(a[7:0] ^ a[15:8] ^ 8'hA5));
    end
  endtask : xfer

  task automatic pulse_irq();
    @(posedge clk);
    irq_event <= 1'b1;
    @(posedge clk);
    irq_event <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse_irq

  // ************************************************
  // sequence
  // ************************************************
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    int n;
    logic v;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    check(16'({dma_fetch_req_n, dma_store_req_n, irq_out_n, reply_n}), 16'h000F);
    pio(1'b0, 2'h1, 8'h00);
    check(16'(q), 16'h0014);
    @(posedge clk);
    term_ready <= 1'b0;
    remote_loop <= 1'b1;
    local_loop <= 1'b0;
    pio(1'b0, 2'h1, 8'h00);
    check(16'(q), 16'h0008);
    $display("test reset and status done");
    xfer(1'b0, 16'h12C4, 8'h00);
    wait_cycles <= 8'h05;
    xfer(1'b0, 16'hFFFF, 8'h00);
    xfer(1'b1, 16'h8001, 8'h3C);
    wait_cycles <= 8'h00;
    xfer(1'b1, 16'h0000, 8'hC3);
    $display("test dma done");
    pio(1'b1, 2'h0, 8'h07);
    pulse_irq();
    check(16'(irq_out_n), 16'h0000);
    pio(1'b1, 2'h1, 8'h01);
    repeat (2) @(posedge clk);
    #1;
    check(16'(irq_out_n), 16'h0001);
    pulse_irq();
    check(16'(irq_out_n), 16'h0000);
    @(posedge clk);
    master_clear_n <= 1'b0;
    @(posedge clk);
    master_clear_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    check(16'(irq_out_n), 16'h0001);
    pio(1'b0, 2'h0, 8'h00);
    check(16'(q), 16'h0003);
    $display("test irq and clear done");
    @(posedge clk);
    tx_speed_sel <= 4'hA;
    rx_speed_sel <= 4'hC;
    rate_switchpack <= 8'h6F;
    pio(1'b0, 2'h2, 8'h00);
    check(16'(q), 16'h004A);
    pio(1'b0, 2'h3, 8'h00);
    check(16'(q), 16'h000C);
    @(posedge clk);
    tx_speed_sel <= 4'hF;
    rx_speed_sel <= 4'hF;
    rate_switchpack <= 8'hFF;
    repeat (2) begin
      n = 0;
      v = tx_bit_clk;
      do begin
        @(posedge clk);
        n++;
      end while (tx_bit_clk === v && n < 400);
      check(16'(n < 400), 16'h0001);
    end
    // second interval is a whole half period of the fastest code
    check(16'(n), 16'(link_port_pkg::RATE_DIV[15] * link_port_pkg::SYS_TICK_CYCLES));
    n = 0;
    v = rx_bit_clk;
    do begin
      @(posedge clk);
      n++;
    end while (rx_bit_clk === v && n < 400);
    check(16'(n < 400), 16'h0001);
    $display("test rates done");
    summarize();
  end
endmodule : tb_link_board_host_port
